/* File: hdl/tst_self_test.sv */
// Summary of operation
// - tape test: track A, auto-verify, rewind, mark 1,0, write 256; then track B, rewind, mark 1,0, write 256
// - second drive with writable cartridge gets the whole tape test too
// - tests 1-5 always; tape test only on command or switch start
// - lamp never flashes while the self-test switch is on
// - error output returns five bytes: primary, secondary, electronics, d0, d1
// - primary weights 0,1,2,4,8 for pass and basic tape faults
// - primary weights 16,32,64,128 for overflow, checksum, tape end, servo
// - secondary weights 1,2,4,8 for byte, character and parameter faults
// - secondary weights 16,32,64 for parameter count, limits, syntax
// - electronics codes 16,36,37,40,41 for select and bus faults
// - electronics codes 64,65,66 for tape controller faults
// - electronics codes 128 for ROM, 129-132 for memory devices
// - fourth and fifth bytes carry drive results in primary encoding
// - single-drive unit always returns zero as fifth byte
// - memory failure right after power-up flashes the lamp
// - identify, data in, data out, poll wait for their follow-up action
// - search issued while a read is pending is an error
// - status instruction clears error, back to ready; error output clears secondary faults, then results until end character
// - steps run in order: memory, ROM, controller, select, output reg
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tst_params.svh"
module tst_self_test #(
  parameter int DRIVES = 2,
  parameter logic [7:0] ID_CODE = 8'h5a, // arbitrary value
  parameter int FLASH_CYCLES = `TST_FLASH_NS / `TST_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire tst_pkg::tst_axi_req_type axiReq,
  output var tst_pkg::tst_axi_rsp_type axiRsp,
  input wire logic testSwitch,
  input wire logic [1:0] cartWritable,
  output var tst_pkg::tst_step_req_type stepReq,
  input wire tst_pkg::tst_step_rsp_type stepRsp,
  output var tst_pkg::tst_tape_req_type tapeReq,
  input wire tst_pkg::tst_tape_rsp_type tapeRsp,
  output logic lampOn
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic awReady;
    logic awHave;
    logic [7:0] awAddr;
    logic wReady;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    tst_pkg::tst_inst_state_type inst;
    tst_pkg::tst_test_state_type test;
    logic [1:0] settle;
    logic withTape;
    logic fromCmd;
    logic [2:0] stepIdx;
    logic [3:0] opIdx;
    logic [1:0][7:0] drv;
    logic [7:0] elec;
    logic [7:0] sec;
    logic [4:0][7:0] outPar;
    logic [2:0] outIdx;
    logic rdPend;
    logic ramFail;
    logic testDone;
    logic [3:0] lastCmd;
    tst_pkg::tst_step_req_type step;
    tst_pkg::tst_tape_req_type tape;
  } tst_core_state_type;

  tst_core_state_type s;
  tst_core_state_type n;
  logic [2:0] pinSync;
  logic swOn;
  logic [1:0] cartOn;

  generate
    if (DRIVES < 1 || DRIVES > 2) begin : gBad
      $error("tst_self_test: DRIVES must be 1 or 2");
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin synchronisers and lamp
  // ---------------------------------------------------------------
  tst_sync #(
    .W(3)
  ) uSync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .din({testSwitch, cartWritable}),
    .dout(pinSync)
  );

  assign swOn = pinSync[2];
  assign cartOn = pinSync[1:0];

  // flash on memory fault, held dark while switch is on
  tst_lamp #(
    .HALF_CYCLES(FLASH_CYCLES)
  ) uLamp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .flash(s.ramFail && !swOn),
    .lamp(lampOn)
  );

  // ---------------------------------------------------------------
  // tape test operation order
  // ---------------------------------------------------------------
  function automatic tst_pkg::tst_tape_op_type opAt(
    input logic [3:0] idx
  );
    tst_pkg::tst_tape_op_type op;
    op = tst_pkg::TST_OP_TRACK_A;
    unique case (idx)
      4'h1: op = tst_pkg::TST_OP_AUTO_VERIFY;
      4'h2, 4'h6: op = tst_pkg::TST_OP_REWIND;
      4'h3, 4'h7: op = tst_pkg::TST_OP_MARK_FILE;
      4'h4, 4'h8: op = tst_pkg::TST_OP_WRITE;
      4'h5: op = tst_pkg::TST_OP_TRACK_B;
      default: op = tst_pkg::TST_OP_TRACK_A;
    endcase
    return op;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic doRd;
    logic cmdWr;
    logic outWr;
    logic inRd;
    logic busy;
    logic startCmd;
    logic finish;
    logic second;
    logic clrSec;
    logic [7:0] secSet;
    logic [7:0] rByte;
    logic rEnd;
    logic [3:0] code;
    logic [7:0] prim;
    doRd = 1'b0;
    cmdWr = 1'b0;
    outWr = 1'b0;
    inRd = 1'b0;
    startCmd = 1'b0;
    finish = 1'b0;
    clrSec = 1'b0;
    secSet = `TST_SEC_NONE;
    rByte = 8'h00;
    rEnd = 1'b0;
    n = s;
    busy = (s.test != tst_pkg::TST_T_IDLE);
    second = (DRIVES == 2) && s.withTape && cartOn[1];
    code = s.wData[`TST_CMD_MSB:`TST_CMD_LSB];
    prim = s.drv[0] | s.drv[1];

    // write channel: address and data taken in either order
    if (axiReq.awvalid && s.awReady) begin
      n.awHave = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s.wReady) begin
      n.wHave = 1'b1;
      n.wData = axiReq.wdata;
      n.wStrb = axiReq.wstrb;
    end
    if (axiReq.bready && s.bValid) begin
      n.bValid = 1'b0;
    end
    if (s.awHave && s.wHave && !s.bValid) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = `TST_RESP_OK;
      if (s.awAddr == `TST_OFS_CMD) begin
        cmdWr = s.wStrb[0];
      end else if (s.awAddr == `TST_OFS_HOUT) begin
        outWr = s.wStrb[0];
      end else begin
        n.bResp = `TST_RESP_ERR;
      end
    end
    n.awReady = !n.awHave;
    n.wReady = !n.wHave;

    // read channel: one read outstanding
    if (axiReq.rready && s.rValid) begin
      n.rValid = 1'b0;
    end
    if (axiReq.arvalid && s.arReady) begin
      doRd = 1'b1;
      inRd = (axiReq.araddr == `TST_OFS_HIN);
    end

    // host requests a byte: answer depends on instruction state
    if (inRd) begin
      unique case (s.inst)
        tst_pkg::TST_I_IDENT: begin
          rByte = ID_CODE;
          n.inst = tst_pkg::TST_I_READY;
        end
        tst_pkg::TST_I_POLL: begin
          rByte = {6'h00, s.testDone, busy};
          n.inst = tst_pkg::TST_I_READY;
        end
        tst_pkg::TST_I_DATAOUT: begin
          rByte = `TST_END_CHAR;
          rEnd = 1'b1;
          n.rdPend = 1'b0;
          n.inst = tst_pkg::TST_I_READY;
        end
        tst_pkg::TST_I_RESULTS: begin
          if (s.outIdx == `TST_LAST_PARAM) begin
            rByte = `TST_END_CHAR;
            rEnd = 1'b1;
            n.inst = tst_pkg::TST_I_READY;
          end else begin
            rByte = s.outPar[s.outIdx];
            n.outIdx = s.outIdx + 3'h1;
          end
        end
        default: begin
          secSet = secSet | `TST_SEC_BYTE_REQ;
          n.inst = tst_pkg::TST_I_ERROR;
        end
      endcase
    end

    // host sends a byte: only a data list is expected
    if (outWr) begin
      if (s.inst == tst_pkg::TST_I_DATAIN) begin
        if (s.wData[`TST_HOUT_END]) begin
          n.inst = tst_pkg::TST_I_READY;
        end
      end else begin
        secSet = secSet | `TST_SEC_BYTE_RX;
        n.inst = tst_pkg::TST_I_ERROR;
      end
    end

    // instruction decode
    if (cmdWr) begin
      n.lastCmd = code;
      if (code == tst_pkg::TST_INS_STATUS) begin
        n.inst = tst_pkg::TST_I_READY;
      end else if (code == tst_pkg::TST_INS_ERR_OUT) begin
        n.outPar[0] = prim;
        n.outPar[1] = s.sec | secSet;
        n.outPar[2] = s.elec;
        n.outPar[3] = s.drv[0];
        n.outPar[4] = (DRIVES == 2) ? s.drv[1] : 8'h00;
        n.outIdx = 3'h0;
        clrSec = 1'b1;
        n.inst = tst_pkg::TST_I_RESULTS;
      end else if (s.inst != tst_pkg::TST_I_READY || busy) begin
        secSet = secSet | `TST_SEC_BYTE_RX;
        n.inst = tst_pkg::TST_I_ERROR;
      end else begin
        unique case (code)
          tst_pkg::TST_INS_SELF_TEST: startCmd = 1'b1;
          tst_pkg::TST_INS_IDENTIFY: n.inst = tst_pkg::TST_I_IDENT;
          tst_pkg::TST_INS_DATA_IN: n.inst = tst_pkg::TST_I_DATAIN;
          tst_pkg::TST_INS_DATA_OUT: n.inst = tst_pkg::TST_I_DATAOUT;
          tst_pkg::TST_INS_POLL: n.inst = tst_pkg::TST_I_POLL;
          tst_pkg::TST_INS_READ: n.rdPend = 1'b1;
          tst_pkg::TST_INS_MARK: n.inst = tst_pkg::TST_I_READY;
          tst_pkg::TST_INS_SEARCH: begin
            if (s.rdPend) begin
              secSet = secSet | `TST_SEC_SYNTAX;
              n.inst = tst_pkg::TST_I_ERROR;
            end
          end
          default: begin
            secSet = secSet | `TST_SEC_SYNTAX;
            n.inst = tst_pkg::TST_I_ERROR;
          end
        endcase
      end
    end

    // sticky interface faults, a new fault beats the clear
    n.sec = (clrSec ? `TST_SEC_NONE : s.sec) | secSet;

    // self-test sequencer
    unique case (s.test)
      tst_pkg::TST_T_IDLE: begin
        if (startCmd) begin
          n.withTape = 1'b1;
          n.fromCmd = 1'b1;
        end
      end
      tst_pkg::TST_T_SETTLE: begin
        n.settle = s.settle + 2'h1;
        if (s.settle == `TST_SETTLE) begin
          n.withTape = swOn;
          n.fromCmd = 1'b0;
        end
      end
      tst_pkg::TST_T_STEP: begin
        if (stepRsp.done) begin
          if (stepRsp.code != 8'h00 && s.elec == 8'h00) begin
            n.elec = stepRsp.code;
          end
          if (s.stepIdx == 3'h0 && !s.fromCmd
              && stepRsp.code >= `TST_RAM_CODE_LO
              && stepRsp.code <= `TST_RAM_CODE_HI) begin
            n.ramFail = 1'b1;
          end
          if (s.stepIdx == `TST_LAST_STEP) begin
            n.step.valid = 1'b0;
            if (s.withTape && cartOn[0]) begin
              n.test = tst_pkg::TST_T_TAPE;
              n.tape.drive = 1'b0;
              n.opIdx = 4'h0;
            end else if (second) begin
              n.test = tst_pkg::TST_T_TAPE;
              n.tape.drive = 1'b1;
              n.opIdx = 4'h0;
            end else begin
              finish = 1'b1;
            end
          end else begin
            n.stepIdx = s.stepIdx + 3'h1;
          end
        end
      end
      tst_pkg::TST_T_TAPE: begin
        if (tapeRsp.done) begin
          n.drv[s.tape.drive] = s.drv[s.tape.drive]
                                | tapeRsp.status;
          if (s.opIdx == `TST_LAST_OP) begin
            if (!s.tape.drive && second) begin
              n.tape.drive = 1'b1;
              n.opIdx = 4'h0;
            end else begin
              finish = 1'b1;
            end
          end else begin
            n.opIdx = s.opIdx + 4'h1;
          end
        end
      end
    endcase

    // start of a run: power-up after settling, or command
    if ((s.test == tst_pkg::TST_T_SETTLE && s.settle == `TST_SETTLE)
        || (s.test == tst_pkg::TST_T_IDLE && startCmd)) begin
      n.test = tst_pkg::TST_T_STEP;
      n.stepIdx = 3'h0;
      n.step.valid = 1'b1;
      n.elec = 8'h00;
      n.drv = '0;
      n.testDone = 1'b0;
    end
    if (finish) begin
      n.test = tst_pkg::TST_T_IDLE;
      n.testDone = 1'b1;
    end
    n.step.sel = n.stepIdx + 3'h1;
    n.tape.valid = (n.test == tst_pkg::TST_T_TAPE);
    n.tape.op = opAt(n.opIdx);
    n.tape.fileNum = `TST_MARK_FILE;
    n.tape.recNum = `TST_MARK_REC;
    n.tape.byteCount = `TST_WRITE_BYTES;

    // read data mux
    if (doRd) begin
      n.rValid = 1'b1;
      n.rResp = `TST_RESP_OK;
      unique case (axiReq.araddr)
        `TST_OFS_CMD: n.rData = {28'h0000000, s.lastCmd};
        `TST_OFS_HIN: n.rData = {23'h000000, rEnd, rByte};
        `TST_OFS_STAT:
          n.rData = {22'h000000, s.ramFail, s.testDone, busy, s.inst};
        `TST_OFS_RES0: n.rData = {8'h00, s.elec, s.sec, prim};
        `TST_OFS_RES1: n.rData = {16'h0000, s.drv[1], s.drv[0]};
        default: begin
          n.rData = 32'h00000000;
          n.rResp = `TST_RESP_ERR;
        end
      endcase
    end
    n.arReady = !n.rValid;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
      s.inst <= tst_pkg::TST_I_READY;
      s.test <= tst_pkg::TST_T_SETTLE;
      s.step.sel <= 3'h1;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign axiRsp = {s.awReady, s.wReady, s.bValid, s.bResp, s.arReady,
                   s.rValid, s.rData, s.rResp};
  assign stepReq = s.step;
  assign tapeReq = s.tape;
endmodule
`default_nettype wire

/* File: hdl/tst_params.svh */
`ifndef TST_PARAMS_SVH
`define TST_PARAMS_SVH
// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define TST_ADDR_W 8
`define TST_OFS_CMD 8'h00
`define TST_OFS_HOUT 8'h04
`define TST_OFS_HIN 8'h08
`define TST_OFS_STAT 8'h0c
`define TST_OFS_RES0 8'h10
`define TST_OFS_RES1 8'h14
`define TST_RESP_OK 2'h0
`define TST_RESP_ERR 2'h2
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TST_CMD_LSB 0
`define TST_CMD_MSB 3
`define TST_HOUT_END 8
// ---------------------------------------------------------------
// interface fault weights, combined by OR
// ---------------------------------------------------------------
`define TST_SEC_NONE 8'h00
`define TST_SEC_BYTE_RX 8'h01
`define TST_SEC_BYTE_REQ 8'h02
`define TST_SEC_SYNTAX 8'h40
// ---------------------------------------------------------------
// self-test sequencing
// ---------------------------------------------------------------
`define TST_LAST_STEP 3'h4
`define TST_LAST_OP 4'h8
`define TST_LAST_PARAM 3'h5
`define TST_SETTLE 2'h2
`define TST_RAM_CODE_LO 8'h81
`define TST_RAM_CODE_HI 8'h84
`define TST_MARK_FILE 8'h01
`define TST_MARK_REC 8'h00
`define TST_WRITE_BYTES 9'h100
`define TST_END_CHAR 8'h0a
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TST_CLK_NS 8
`define TST_FLASH_NS 250000000
`endif

/* File: hdl/tst_pkg.sv */
`default_nettype none
package tst_pkg;
  // instruction codes written to the command register
  typedef enum logic [3:0] {
    TST_INS_SELF_TEST = 4'h1,
    TST_INS_STATUS = 4'h2,
    TST_INS_ERR_OUT = 4'h3,
    TST_INS_IDENTIFY = 4'h4,
    TST_INS_DATA_IN = 4'h5,
    TST_INS_DATA_OUT = 4'h6,
    TST_INS_POLL = 4'h7,
    TST_INS_SEARCH = 4'h8,
    TST_INS_READ = 4'h9,
    TST_INS_MARK = 4'ha
  } tst_instr_type;

  // instruction state, one-hot
  typedef enum logic [6:0] {
    TST_I_READY = 7'h01,
    TST_I_IDENT = 7'h02,
    TST_I_DATAIN = 7'h04,
    TST_I_DATAOUT = 7'h08,
    TST_I_POLL = 7'h10,
    TST_I_RESULTS = 7'h20,
    TST_I_ERROR = 7'h40
  } tst_inst_state_type;

  // self-test sequencer state, one-hot
  typedef enum logic [3:0] {
    TST_T_IDLE = 4'h1,
    TST_T_SETTLE = 4'h2,
    TST_T_STEP = 4'h4,
    TST_T_TAPE = 4'h8
  } tst_test_state_type;

  // tape operations issued by the tape test
  typedef enum logic [2:0] {
    TST_OP_TRACK_A = 3'h0,
    TST_OP_AUTO_VERIFY = 3'h1,
    TST_OP_REWIND = 3'h2,
    TST_OP_MARK_FILE = 3'h3,
    TST_OP_WRITE = 3'h4,
    TST_OP_TRACK_B = 3'h5
  } tst_tape_op_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } tst_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tst_axi_rsp_type;

  typedef struct packed {
    logic valid;
    logic [2:0] sel;
  } tst_step_req_type;

  typedef struct packed {
    logic done;
    logic [7:0] code;
  } tst_step_rsp_type;

  typedef struct packed {
    logic valid;
    logic drive;
    tst_tape_op_type op;
    logic [7:0] fileNum;
    logic [7:0] recNum;
    logic [8:0] byteCount;
  } tst_tape_req_type;

  typedef struct packed {
    logic done;
    logic [7:0] status;
  } tst_tape_rsp_type;
endpackage
`default_nettype wire

/* File: hdl/tst_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tst_sync #(
  parameter int W = 3
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tst_sync_state_type;

  tst_sync_state_type s;
  tst_sync_state_type n;

  generate
    if (W < 1) begin : gBad
      $error("tst_sync: width must be at least 1");
    end
  endgenerate

  // two-stage capture of pin levels
  always_comb begin
    n.s1 = din;
    n.s2 = s.s1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign dout = s.s2;
endmodule
`default_nettype wire

/* File: hdl/tst_lamp.sv */
`timescale 1ns/1ps
`default_nettype none
module tst_lamp #(
  parameter int HALF_CYCLES = 31250000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic flash,
  output logic lamp
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic lamp;
  } tst_lamp_state_type;

  tst_lamp_state_type s;
  tst_lamp_state_type n;

  generate
    if (HALF_CYCLES < 1) begin : gBad
      $error("tst_lamp: half period must be at least 1");
    end
  endgenerate

  // toggle every half period while flashing, dark otherwise
  always_comb begin
    n = s;
    if (!flash) begin
      n.cnt = '0;
      n.lamp = 1'b0;
    end else if (s.cnt == LAST) begin
      n.cnt = '0;
      n.lamp = !s.lamp;
    end else begin
      n.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign lamp = s.lamp;
endmodule
`default_nettype wire

/* File: dv/tst_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tst_far_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire tst_pkg::tst_step_req_type stepReq,
  input wire tst_pkg::tst_tape_req_type tapeReq,
  input wire logic [2:0] failSel,
  input wire logic [7:0] failCode,
  input wire logic [15:0] tapeStat,
  input wire logic slow,
  output var tst_pkg::tst_step_rsp_type stepRsp,
  output var tst_pkg::tst_tape_rsp_type tapeRsp
);
  logic [3:0] sCnt_reg;
  logic [3:0] tCnt_reg;
  logic [3:0] lim;
  assign lim = slow ? 4'h7 : 4'h1;
  // step and tape engines: one done pulse per request, lim + 1 cycles after it is seen
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sCnt_reg <= 4'h0;
      tCnt_reg <= 4'h0;
      stepRsp <= '0;
      tapeRsp <= '0;
    end else begin
      stepRsp.done <= 1'b0;
      tapeRsp.done <= 1'b0;
      stepRsp.code <= ~stepRsp.code; // meaningless off the pulse
      tapeRsp.status <= ~tapeRsp.status;
      if (stepReq.valid && !stepRsp.done) sCnt_reg <= sCnt_reg + 4'h1;
      if (tapeReq.valid && !tapeRsp.done) tCnt_reg <= tCnt_reg + 4'h1;
      if (stepReq.valid && sCnt_reg == lim) begin
        sCnt_reg <= 4'h0;
        stepRsp.done <= 1'b1;
        stepRsp.code <= stepReq.sel == failSel ? failCode : 8'h00;
      end
      if (tapeReq.valid && tCnt_reg == lim) begin
        tCnt_reg <= 4'h0;
        tapeRsp.done <= 1'b1;
        tapeRsp.status <= tapeReq.drive ? tapeStat[15:8] : tapeStat[7:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tst_self_test_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module tst_self_test_checker #(
  parameter int FLASH_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic testSwitch,
  input wire tst_pkg::tst_step_req_type stepReq,
  input wire tst_pkg::tst_step_rsp_type stepRsp,
  input wire tst_pkg::tst_tape_req_type tapeReq,
  input wire tst_pkg::tst_tape_rsp_type tapeRsp,
  input wire logic lampOn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  int litCnt_reg;
  // count lit lamp cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) litCnt_reg <= 0;
    else litCnt_reg <= lampOn ? litCnt_reg + 1 : 0;
  end
  sequence opDone(o);
    tapeReq.valid && tapeRsp.done && tapeReq.op == o;
  endsequence
  sequence stepDone;
    stepReq.valid && stepRsp.done;
  endsequence
  AST_LAMP_DARK: assert property (testSwitch [*5] |-> !lampOn)
    else $error("lamp lit with switch on");
  AST_LAMP_HALF: assert property (
    $fell(lampOn) && !testSwitch |-> litCnt_reg == FLASH_CYCLES)
    else $error("lamp half period wrong");
  AST_MARK_ARGS: assert property (
    tapeReq.valid && tapeReq.op == tst_pkg::TST_OP_MARK_FILE |->
    tapeReq.fileNum == 8'h01 && tapeReq.recNum == 8'h00)
    else $error("mark file arguments wrong");
  AST_WRITE_LEN: assert property (
    tapeReq.valid && tapeReq.op == tst_pkg::TST_OP_WRITE |->
    tapeReq.byteCount == 9'h100)
    else $error("write length wrong");
  AST_VERIFY_AFTER_A: assert property (
    opDone(tst_pkg::TST_OP_TRACK_A) |=>
    tapeReq.op == tst_pkg::TST_OP_AUTO_VERIFY)
    else $error("verify setting not after track A");
  AST_STEP_FIRST: assert property (
    $rose(stepReq.valid) |-> stepReq.sel == 3'h1)
    else $error("first step not memory");
  AST_STEP_NEXT: assert property (
    stepDone ##0 stepReq.sel != 3'h5 |=>
    stepReq.sel == $past(stepReq.sel) + 3'h1)
    else $error("step order wrong");
  AST_STEP_END: assert property (
    stepDone ##0 stepReq.sel == 3'h5 |=> !stepReq.valid)
    else $error("steps run past five");
endmodule
bind tst_self_test tst_self_test_checker #(.FLASH_CYCLES(FLASH_CYCLES)) chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .testSwitch(testSwitch),
  .stepReq(stepReq), .stepRsp(stepRsp), .tapeReq(tapeReq),
  .tapeRsp(tapeRsp), .lampOn(lampOn));
`default_nettype wire

/* File: dv/tb_tape_unit_self_test_and_error_report.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tst_params.svh"
module tb_tape_unit_self_test_and_error_report;
  typedef struct packed {
    logic [1:0] op;
    logic [8:0] dat;
    logic [6:0] st;
  } tst_row_type;
  // op 0 command, 1 checked byte request, 2 host byte, 3 stray request
  tst_row_type rows [25] = '{
    '{2'h0,9'h003,7'h20}, '{2'h1,9'h008,7'h20}, '{2'h1,9'h000,7'h20},
    '{2'h1,9'h000,7'h20}, '{2'h1,9'h008,7'h20}, '{2'h1,9'h000,7'h20},
    '{2'h1,9'h10a,7'h01}, '{2'h0,9'h004,7'h02}, '{2'h1,9'h05a,7'h01},
    '{2'h0,9'h005,7'h04}, '{2'h2,9'h033,7'h04}, '{2'h2,9'h10a,7'h01},
    '{2'h0,9'h006,7'h08}, '{2'h1,9'h10a,7'h01}, '{2'h0,9'h007,7'h10},
    '{2'h1,9'h002,7'h01}, '{2'h3,9'h000,7'h40}, '{2'h0,9'h002,7'h01},
    '{2'h0,9'h009,7'h01}, '{2'h0,9'h008,7'h40}, '{2'h0,9'h002,7'h01},
    '{2'h2,9'h011,7'h40}, '{2'h0,9'h002,7'h01}, '{2'h0,9'h00f,7'h40},
    '{2'h0,9'h002,7'h01}};
  localparam logic [2:0] SEQ [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5,
    3'h2, 3'h3, 3'h4};
  logic sys_clk = 1'b0;
  logic reset_n, testSwitch, slow, lampOn;
  logic [1:0] cartWritable, r;
  logic [2:0] failSel;
  logic [7:0] failCode;
  logic [15:0] tapeStat;
  logic [31:0] d;
  logic [3:0] opLog [$];
  tst_pkg::tst_axi_req_type axiReq;
  tst_pkg::tst_axi_rsp_type axiRsp;
  tst_pkg::tst_step_req_type stepReq;
  tst_pkg::tst_step_rsp_type stepRsp;
  tst_pkg::tst_tape_req_type tapeReq;
  tst_pkg::tst_tape_rsp_type tapeRsp;
  int err_total = 0;
  int checked = 0;
  int n;
  tst_self_test #(.DRIVES(2), .FLASH_CYCLES(4)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .testSwitch(testSwitch), .cartWritable(cartWritable),
    .stepReq(stepReq), .stepRsp(stepRsp), .tapeReq(tapeReq),
    .tapeRsp(tapeRsp), .lampOn(lampOn));
  tst_far_model far (
    .sys_clk(sys_clk), .reset_n(reset_n), .stepReq(stepReq),
    .tapeReq(tapeReq), .failSel(failSel), .failCode(failCode),
    .tapeStat(tapeStat), .slow(slow), .stepRsp(stepRsp), .tapeRsp(tapeRsp));
  // clock
  always #4 sys_clk = ~sys_clk;
  // log each finished tape operation with its drive
  always @(posedge sys_clk) begin
    if (tapeRsp.done && tapeReq.valid)
      opLog.push_back({tapeReq.drive, tapeReq.op});
  end
  task automatic wrap_up();
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    axiReq.awaddr <= a;
    axiReq.wdata <= v;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!axiRsp.bvalid);
    r = axiRsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
  endtask
  task automatic wait_idle();
    repeat (4) @(posedge sys_clk);
    do rd(`TST_OFS_STAT); while (d[7]);
  endtask
  task automatic chk_ops(input int k);
    chk("tape ops", 32'(opLog.size()), 32'(k));
    foreach (opLog[i])
      chk("tape op", {28'h0, opLog[i]}, {28'h0, 1'(i / 9), SEQ[i % 9]});
    opLog.delete();
  endtask
  // main sequence
  initial begin
    reset_n = 1'b0;
    axiReq = '0;
    testSwitch = 1'b1;
    cartWritable = 2'h1;
    failSel = 3'h0;
    failCode = 8'h00;
    tapeStat = 16'h4008;
    slow = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_idle();
    chk_ops(9);
    testSwitch <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].op == 2'h0) axw(`TST_OFS_CMD, 32'(rows[i].dat));
      else if (rows[i].op == 2'h2) axw(`TST_OFS_HOUT, 32'(rows[i].dat));
      else begin
        rd(`TST_OFS_HIN);
        if (rows[i].op == 2'h1)
          chk("byte", 32'(d[8:0]), 32'(rows[i].dat));
      end
      rd(`TST_OFS_STAT);
      chk("state", 32'(d[6:0]), 32'(rows[i].st));
    end
    rd(`TST_OFS_RES0);
    chk("secondary", 32'(d[15:8]), 32'h43);
    cartWritable <= 2'h3;
    axw(`TST_OFS_CMD, 32'h1);
    wait_idle();
    chk_ops(18);
    rd(`TST_OFS_RES1);
    chk("drives", d, 32'h4008);
    cartWritable <= 2'h0;
    axw(`TST_OFS_CMD, 32'h1);
    wait_idle();
    chk_ops(0);
    axw(8'h20, 32'h1);
    chk("bresp", 32'(r), 32'h2);
    rd(8'h20);
    chk("rresp", 32'(r), 32'h2);
    reset_n <= 1'b0;
    failSel <= 3'h1;
    failCode <= 8'h81;
    slow <= 1'b1;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_idle();
    chk("mem fail", 32'(d[9]), 32'h1);
    rd(`TST_OFS_RES0);
    chk("electronics", 32'(d[23:16]), 32'h81);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      n += int'(lampOn);
    end
    chk("lamp", 32'(n > 15 && n < 25), 32'h1);
    testSwitch <= 1'b1;
    repeat (4) @(posedge sys_clk);
    n = 0;
    repeat (20) begin
      @(posedge sys_clk);
      n += int'(lampOn);
    end
    chk("lamp held", 32'(n), 32'h0);
    wrap_up();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
